// File: src/ssra_device.sv
// Device end: serial slave with a 142-byte register file.
// Assumes clk is much faster than the serial clock; link pins are asynchronous.
//
// Contract
// - Opcode 03 reads, 02 writes.
// - Master holds select low to burst read.
// - After each read byte address advances, next shifts.
// - Burst read ends when select rises.
// - Master holds select low to burst write.
// - After each write byte address advances, next stored.
// - Burst write stops when select rises.
// - Address wraps to zero past register 141.
// - Serial clock at most 5 MHz.
// - Output data changes on falling serial clock.
// - Input sampled on rising serial clock.
// - Active only when strap reads binary 10.
// - Run enable bit cleared at reset.
// - Run enable cannot be cleared once set.
// - Master configures and verifies before starting.
// - Live settings stay writable while running.
// - Registers 121 to 131 reach tables indirectly.
`timescale 1ns/1ps
`include "ssra_defines.svh"
module ssra_device (
   input  wire logic           clk,
   input  wire logic           sys_rst,
   ssra_link_if.dev            link,
   input  wire logic [1:0]     portSelectStrap,
   output logic                switchRun,
   output logic                indirectStrobe,
   output ssra_pkg::ssra_addr_type indirectAddr,
   output ssra_pkg::ssra_byte_type indirectData,
   input  wire ssra_pkg::ssra_byte_type indirectReadData,
   output ssra_pkg::ssra_byte_type cfgView
);
   import ssra_pkg::*;

   typedef enum logic [3:0] {
      ST_CMD  = 4'b0001,
      ST_ADDR = 4'b0010,
      ST_DATA = 4'b0100,
      ST_IDLE = 4'b1000
   } ssra_state_type;

   // ==========================================================
   // Pin synchronisers.
   logic [2:0] selS_r, sckS_r, sdiS_r;
   logic       selQ_r, sckQ_r;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         selS_r <= 3'h7;
         sckS_r <= 3'h0;
         sdiS_r <= 3'h0;
         selQ_r <= 1'b1;
         sckQ_r <= 1'b0;
      end else begin
         selS_r <= {selS_r[1:0], link.targetSelectN};
         sckS_r <= {sckS_r[1:0], link.serialClockIn};
         sdiS_r <= {sdiS_r[1:0], link.serialDataIn};
         if (selS_r[1] == selS_r[2]) selQ_r <= selS_r[2];
         if (sckS_r[1] == sckS_r[2]) sckQ_r <= sckS_r[2];
      end
   end

   // Strap passes three flops and is caught once, after the pipe has filled and the last two agree.
   // The mode is settled four edges after release, before the first select can reach the engine.
   logic [1:0] strapA_r, strapB_r, strapC_r, strapFill_r;
   logic       strapDone_r;
   logic       modeOn_r;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         strapA_r    <= 2'h0;
         strapB_r    <= 2'h0;
         strapC_r    <= 2'h0;
         strapFill_r <= 2'h0;
         strapDone_r <= 1'b0;
         modeOn_r    <= 1'b0;
      end else begin
         strapA_r <= portSelectStrap;
         strapB_r <= strapA_r;
         strapC_r <= strapB_r;
         if (strapFill_r != `SSRA_STRAP_FILL) strapFill_r <= 2'(strapFill_r + 2'h1);
         if (!strapDone_r && (strapFill_r == `SSRA_STRAP_FILL) && (strapB_r == strapC_r)) begin
            strapDone_r <= 1'b1;
            modeOn_r    <= (strapC_r == `SSRA_MODE_SPI);
         end
      end
   end

   // ==========================================================
   // Edge decode.
   wire selActive = modeOn_r && !selQ_r;
   wire sckRise   = (sckS_r[1] == sckS_r[2]) && sckS_r[2] && !sckQ_r;
   wire sckFall   = (sckS_r[1] == sckS_r[2]) && !sckS_r[2] && sckQ_r;
   wire sdiBit    = sdiS_r[2];

   function automatic ssra_addr_type nextAddr(input ssra_addr_type a);
      nextAddr = (a == `SSRA_REG_LAST) ? 8'h00 : 8'(a + 8'h01);
   endfunction

   // ==========================================================
   // Register file and serial engine.
   ssra_byte_type  regs_r [0:`SSRA_REG_COUNT-1];
   ssra_state_type state_r;
   logic [2:0]     bitCnt_r;
   ssra_byte_type  shIn_r, shOut_r;
   ssra_addr_type  addr_r;
   logic           isRead_r, sdo_r, idxStb_r;
   ssra_addr_type  idxAddr_r;
   ssra_byte_type  idxData_r;

   wire [7:0]     inByte   = {shIn_r[6:0], sdiBit};
   wire           byteDone = sckRise && (bitCnt_r == 3'h7);
   wire           isInd    = (addr_r >= `SSRA_IND_FIRST) && (addr_r <= `SSRA_IND_LAST);
   wire ssra_byte_type rdSrc = isInd ? indirectReadData : regs_r[addr_r];
   wire           wrNow    = selActive && byteDone && (state_r == ST_DATA) && !isRead_r;
   // Run bit may be set but never cleared; other bits stay writable.
   wire ssra_byte_type wrVal = (addr_r == `SSRA_REG_START) ?
                               (inByte | {7'h00, regs_r[`SSRA_REG_START][`SSRA_START_BIT]}) : inByte;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_r  <= ST_CMD;
         bitCnt_r <= 3'h0;
         shIn_r   <= 8'h00;
         shOut_r  <= 8'h00;
         addr_r   <= 8'h00;
         isRead_r <= 1'b0;
         sdo_r    <= 1'b0;
      end else if (!selActive) begin
         state_r  <= ST_CMD;
         bitCnt_r <= 3'h0;
      end else begin
         if (sckRise) begin
            shIn_r   <= inByte;
            bitCnt_r <= 3'(bitCnt_r + 3'h1);
         end
         if (byteDone) begin
            case (state_r)
               ST_CMD: begin
                  isRead_r <= (inByte == `SSRA_CMD_READ);
                  state_r  <= ((inByte == `SSRA_CMD_READ) || (inByte == `SSRA_CMD_WRITE)) ? ST_ADDR : ST_IDLE;
               end
               ST_ADDR: begin
                  addr_r  <= (inByte > `SSRA_REG_LAST) ? 8'h00 : inByte;
                  state_r <= ST_DATA;
               end
               ST_DATA: addr_r <= nextAddr(addr_r);
               default: state_r <= ST_IDLE;
            endcase
         end
         if (state_r == ST_DATA && isRead_r && sckFall && bitCnt_r == 3'h0) begin
            sdo_r   <= rdSrc[7];
            shOut_r <= {rdSrc[6:0], 1'b0};
         end else if (sckFall) begin
            sdo_r   <= shOut_r[7];
            shOut_r <= {shOut_r[6:0], 1'b0};
         end
      end
   end

   // Register writes; the run bit is cleared at reset.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int i = 0; i < `SSRA_REG_COUNT; i++) regs_r[i] <= 8'h00;
      end else if (wrNow && !isInd) begin
         regs_r[addr_r] <= wrVal;
      end
   end

   // Indirect window strobe toward the table logic.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         idxStb_r  <= 1'b0;
         idxAddr_r <= 8'h00;
         idxData_r <= 8'h00;
      end else begin
         idxStb_r <= wrNow && isInd;
         if (wrNow && isInd) begin
            idxAddr_r <= addr_r;
            idxData_r <= inByte;
         end
      end
   end

   // Registered outputs.
   logic          run_r;
   ssra_byte_type cfg_r;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         run_r <= 1'b0;
         cfg_r <= 8'h00;
      end else begin
         run_r <= regs_r[`SSRA_REG_START][`SSRA_START_BIT];
         cfg_r <= regs_r[`SSRA_REG_START];
      end
   end

   assign link.serialDataOut = sdo_r;
   assign switchRun          = run_r;
   assign cfgView            = cfg_r;
   assign indirectStrobe     = idxStb_r;
   assign indirectAddr       = idxAddr_r;
   assign indirectData       = idxData_r;
endmodule

// File: common/ssra_defines.svh
// Constants shared by both ends of the serial register access link.
// Assumes a 125 MHz system clock on both ends.
`ifndef SSRA_DEFINES_SVH
`define SSRA_DEFINES_SVH
`define SSRA_CMD_READ       8'h03
`define SSRA_CMD_WRITE      8'h02
`define SSRA_REG_COUNT      142
`define SSRA_REG_LAST       8'h8d
`define SSRA_REG_START      8'h01
`define SSRA_START_BIT      0
`define SSRA_MODE_SPI       2'h2
`define SSRA_STRAP_FILL     2'h3
`define SSRA_IND_FIRST      8'h79
`define SSRA_IND_LAST       8'h83
`define SSRA_SYS_CLK_MHZ    125
`define SSRA_SCK_MAX_MHZ    5
`define SSRA_SCK_HALF       ((`SSRA_SYS_CLK_MHZ + 2 * `SSRA_SCK_MAX_MHZ - 1) / (2 * `SSRA_SCK_MAX_MHZ))
`endif

// File: common/ssra_pkg.sv
// Types shared by both ends of the serial register access link.
// Assumes the constants header is available on the include path.
package ssra_pkg;
   typedef logic [7:0] ssra_byte_type;
   typedef logic [7:0] ssra_addr_type;
endpackage

// File: common/ssra_link_if.sv
// Serial link wires between the controller end and the device end.
// Assumes both ends share nothing but these four wires.
`timescale 1ns/1ps
interface ssra_link_if;
   logic targetSelectN;
   logic serialClockIn;
   logic serialDataIn;
   logic serialDataOut;
   modport ctrl (output targetSelectN, output serialClockIn, output serialDataIn, input serialDataOut);
   modport dev  (input targetSelectN, input serialClockIn, input serialDataIn, output serialDataOut);
endinterface

// File: src/ssra_controller.sv
// Controller end: issues one read or write burst per run of one-byte requests, ending at reqLast or when no request waits at a byte end.
// Assumes the device end samples on rising and drives on falling serial clock.
`timescale 1ns/1ps
`include "ssra_defines.svh"
module ssra_controller (
   input  wire logic                    clk,
   input  wire logic                    sys_rst,
   ssra_link_if.ctrl                    link,
   input  wire logic                    reqValid,
   input  wire logic                    reqWrite,
   input  wire ssra_pkg::ssra_addr_type reqAddr,
   input  wire ssra_pkg::ssra_byte_type reqData,
   input  wire logic                    reqLast,
   output logic                         reqReady,
   output logic                         rspValid,
   output ssra_pkg::ssra_byte_type      rspData,
   output logic                         busy
);
   import ssra_pkg::*;

   typedef enum logic [2:0] {
      SC_IDLE = 3'b001,
      SC_XFER = 3'b010,
      SC_WAIT = 3'b100
   } ssra_cstate_type;

   // ==========================================================
   // Byte shifter; clock divided to stay at or below 5 MHz.
   ssra_cstate_type st_r;
   logic [7:0]      div_r;
   logic [4:0]      half_r;
   logic [1:0]      phase_r;
   logic [7:0]      shO_r, shI_r, rsp_r;
   logic            sel_r, sck_r, sdo_r, rdy_r, rv_r, write_r, last_r, busy_r;
   logic [2:0]      sdiS_r;

   wire tick     = (div_r == 8'(`SSRA_SCK_HALF - 1));
   wire byteEnd  = tick && sck_r && (half_r == 5'h0f);
   wire [7:0] cmdByte = reqWrite ? `SSRA_CMD_WRITE : `SSRA_CMD_READ;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) sdiS_r <= 3'h0;
      else         sdiS_r <= {sdiS_r[1:0], link.serialDataOut};
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_r <= SC_IDLE; div_r <= 8'h00; half_r <= 5'h00; phase_r <= 2'h0;
         shO_r <= 8'h00; shI_r <= 8'h00; rsp_r <= 8'h00; sel_r <= 1'b1;
         sck_r <= 1'b0; sdo_r <= 1'b0; rdy_r <= 1'b0; rv_r <= 1'b0;
         write_r <= 1'b0; last_r <= 1'b0;
         busy_r  <= 1'b0;
      end else begin
         rdy_r <= 1'b0;
         rv_r  <= 1'b0;
         div_r <= tick ? 8'h00 : 8'(div_r + 8'h01);
         case (st_r)
            SC_IDLE: if (reqValid && !rdy_r) begin
               sel_r   <= 1'b0;
               write_r <= reqWrite;
               last_r  <= reqLast;
               shO_r   <= cmdByte;
               rsp_r   <= reqAddr;
               shI_r   <= reqData;
               sdo_r   <= cmdByte[7];
               busy_r  <= 1'b1;
               phase_r <= 2'h0;
               half_r  <= 5'h00;
               rdy_r   <= 1'b1;
               st_r    <= SC_XFER;
            end
            SC_XFER: if (tick) begin
               sck_r  <= !sck_r;
               half_r <= 5'(half_r + 5'h01);
               if (!sck_r) begin
                  shO_r <= {shO_r[6:0], sdiS_r[2]};
               end else begin
                  sdo_r <= shO_r[7];
               end
               if (byteEnd) begin
                  half_r <= 5'h00;
                  // The next byte's first bit goes out at this fall, not a bit that was shifted in.
                  if (phase_r == 2'h0) begin
                     phase_r <= 2'h1;
                     shO_r   <= rsp_r;
                     sdo_r   <= rsp_r[7];
                  end else if (phase_r == 2'h1) begin
                     phase_r <= 2'h2;
                     shO_r   <= write_r ? shI_r : 8'h00;
                     sdo_r   <= write_r && shI_r[7];
                  end else begin
                     // All eight bits were already shifted in at the rising edges.
                     rsp_r <= shO_r;
                     rv_r  <= !write_r;
                     if (last_r) st_r <= SC_WAIT;
                     else if (reqValid) begin
                        shO_r  <= write_r ? reqData : 8'h00;
                        sdo_r  <= write_r && reqData[7];
                        last_r <= reqLast;
                        rdy_r  <= 1'b1;
                     end else st_r <= SC_WAIT;
                  end
               end
            end
            SC_WAIT: if (tick) begin
               sel_r  <= 1'b1;
               busy_r <= 1'b0;
               st_r  <= SC_IDLE;
            end
            default: st_r <= SC_IDLE;
         endcase
      end
   end

   assign link.targetSelectN = sel_r;
   assign link.serialClockIn = sck_r;
   assign link.serialDataIn  = sdo_r;
   assign reqReady = rdy_r;
   assign rspValid = rv_r;
   assign rspData  = rsp_r;
   assign busy     = busy_r;
endmodule

// File: verification/ssra_link_props.sv
// Checker for the four serial link wires between the two ends.
// Assumes it is instantiated beside the link interface in the bench.
`timescale 1ns/1ps
`include "ssra_defines.svh"
module ssra_link_props (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic targetSelectN,
   input wire logic serialClockIn,
   input wire logic serialDataIn,
   input wire logic serialDataOut
);
   // ========================================
   // Helper counters
   logic        sckQ_r;
   logic [7:0]  perCnt_r;
   logic [15:0] bitCnt_r;
   // Edge detect, cycles since the last rise, and rises within a frame.
   wire         sckRise    = serialClockIn & ~sckQ_r;
   wire  [7:0]  perCnt_nxt = sckRise ? 8'h00 : ((perCnt_r == 8'hff) ? perCnt_r : perCnt_r + 8'h01);
   wire  [15:0] bitCnt_nxt = targetSelectN ? 16'h0000 : bitCnt_r + {15'h0000, sckRise};
   // Registers the helper state.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sckQ_r   <= 1'b0;
         perCnt_r <= 8'hff;
         bitCnt_r <= 16'h0000;
      end else begin
         sckQ_r   <= serialClockIn;
         perCnt_r <= perCnt_nxt;
         bitCnt_r <= bitCnt_nxt;
      end
   end
   // ========================================
   // Properties
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   property p_idleClock; targetSelectN |-> !serialClockIn; endproperty
   a_idleClock: assert property (p_idleClock) else $error("serial clock moves outside a frame");
   property p_selFall; $fell(targetSelectN) |-> !serialClockIn; endproperty
   a_selFall: assert property (p_selFall) else $error("select fell with clock high");
   property p_selRise; $rose(targetSelectN) |-> !serialClockIn; endproperty
   a_selRise: assert property (p_selRise) else $error("select rose with clock high");
   property p_frameLen; $rose(targetSelectN) |-> bitCnt_r[2:0] == 3'h0 && bitCnt_r >= 16'h0018; endproperty
   a_frameLen: assert property (p_frameLen) else $error("frame not whole bytes");
   property p_clkRate; sckRise |-> perCnt_r >= 8'h18; endproperty
   a_clkRate: assert property (p_clkRate) else $error("serial clock too fast");
   property p_outFall; $changed(serialDataOut) |-> !serialClockIn; endproperty
   a_outFall: assert property (p_outFall) else $error("output changed with clock high");
   property p_inStable; !targetSelectN && $changed(serialDataIn) |-> !serialClockIn; endproperty
   a_inStable: assert property (p_inStable) else $error("input changed with clock high");
   property p_opZero; sckRise && !targetSelectN && bitCnt_r < 16'h0006 |-> !serialDataIn; endproperty
   a_opZero: assert property (p_opZero) else $error("command upper bits not zero");
   property p_opOne; sckRise && !targetSelectN && bitCnt_r == 16'h0006 |-> serialDataIn; endproperty
   a_opOne: assert property (p_opOne) else $error("command bit one not set");
endmodule

// File: verification/spi_slave_register_access_bench.sv
// Bench joining the controller end and the device end over one link.
// Assumes both design ends and the link checker are compiled first.
`timescale 1ns/1ps
module spi_slave_register_access_bench;
   import ssra_pkg::*;
   logic          clk = 1'b0, sys_rst = 1'b1, reqValid = 1'b0, reqWrite = 1'b0, reqLast = 1'b0;
   logic [1:0]    portSelectStrap = 2'h2;
   ssra_addr_type reqAddr = 8'h00, indirectAddr;
   ssra_byte_type reqData = 8'h00, indirectReadData = 8'h5a, rspData, indirectData, cfgView;
   logic          reqReady, rspValid, busy, switchRun, indirectStrobe;
   int            n_fail = 0, checked = 0, strobes = 0;
   ssra_byte_type rdQ[$];
   ssra_byte_type wbuf[4];
   ssra_link_if   link ();
   // ========================================
   // Design ends and checker
   ssra_controller i_ssra_controller (.clk(clk), .sys_rst(sys_rst), .link(link.ctrl), .reqValid(reqValid),
      .reqWrite(reqWrite), .reqAddr(reqAddr), .reqData(reqData), .reqLast(reqLast), .reqReady(reqReady),
      .rspValid(rspValid), .rspData(rspData), .busy(busy));
   ssra_device i_ssra_device (.clk(clk), .sys_rst(sys_rst), .link(link.dev), .portSelectStrap(portSelectStrap),
      .switchRun(switchRun), .indirectStrobe(indirectStrobe), .indirectAddr(indirectAddr),
      .indirectData(indirectData), .indirectReadData(indirectReadData), .cfgView(cfgView));
   ssra_link_props i_ssra_link_props (.clk(clk), .sys_rst(sys_rst), .targetSelectN(link.targetSelectN),
      .serialClockIn(link.serialClockIn), .serialDataIn(link.serialDataIn), .serialDataOut(link.serialDataOut));
   // 125 MHz system clock.
   always #4 clk = ~clk;
   // Collects read bytes and counts indirect strobes between edges, where the pulses have settled.
   always @(negedge clk) begin
      if (rspValid === 1'b1) rdQ.push_back(rspData);
      if (indirectStrobe === 1'b1) strobes++;
   end
   // ========================================
   // Tasks
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One burst of n bytes; each byte is held until the controller takes it.
   task automatic xfer(input logic wr, input ssra_addr_type addr, input int n);
      int t;
      for (int i = 0; i < n; i++) begin
         @(negedge clk);
         reqValid = 1'b1;
         reqWrite = wr;
         reqAddr  = addr;
         reqData  = wbuf[i];
         reqLast  = (i == n - 1);
         t = 0;
         // Ready is looked at between edges, where its one-cycle pulse has settled.
         do begin
            @(negedge clk);
            t++;
         end while (reqReady !== 1'b1 && t < 3000);
         if (reqReady !== 1'b1) timed_out("request taken");
      end
      @(negedge clk);
      reqValid = 1'b0;
      t = 0;
      while (busy !== 1'b0 && t < 3000) begin
         @(negedge clk);
         t++;
      end
      if (busy !== 1'b0) timed_out("frame end");
      repeat (4) @(negedge clk);
   endtask
   // A wait that runs out counts as a mismatch and ends the run.
   task automatic timed_out(input string what);
      n_fail++;
      $display("ERROR %s expected done seen timeout", what);
      finish_test();
   endtask
   // Burst read compared against the first n entries of wbuf.
   task automatic rd_chk(input ssra_addr_type addr, input int n);
      rdQ.delete();
      xfer(1'b0, addr, n);
      check("read count", 8'(n), 8'(rdQ.size()));
      for (int i = 0; i < n; i++) check("read data", wbuf[i], rdQ[i]);
   endtask
   task automatic finish_test();
      $display("Checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic do_reset();
      sys_rst = 1'b1;
      repeat (6) @(negedge clk);
      sys_rst = 1'b0;
      repeat (2) @(negedge clk);
   endtask
   // ========================================
   // Tests
   initial begin
      do_reset();
      check("run after reset", 8'h00, {7'h00, switchRun});
      check("reg 1 after reset", 8'h00, cfgView);
      wbuf = '{8'h11, 8'h22, 8'h33, 8'h44};
      xfer(1'b1, 8'h8c, 3);
      check("reg 1 after burst end", 8'h00, cfgView);
      rd_chk(8'h8c, 3);
      wbuf[0] = 8'h01;
      xfer(1'b1, 8'h01, 1);
      check("run set", 8'h01, {7'h00, switchRun});
      wbuf[0] = 8'hf0;
      xfer(1'b1, 8'h01, 1);
      check("run held", 8'h01, {7'h00, switchRun});
      check("reg 1 live bits", 8'hf1, cfgView);
      wbuf[0] = 8'ha5;
      xfer(1'b1, 8'h79, 1);
      check("strobe count", 8'h01, strobes[7:0]);
      check("indirect addr", 8'h79, indirectAddr);
      check("indirect data", 8'ha5, indirectData);
      wbuf[0] = 8'h5a;
      rd_chk(8'h83, 1);
      portSelectStrap = 2'h1;
      do_reset();
      wbuf[0] = 8'h01;
      xfer(1'b1, 8'h01, 1);
      check("run in other mode", 8'h00, {7'h00, switchRun});
      check("reg 1 in other mode", 8'h00, cfgView);
      finish_test();
   end
   // Cuts a hang short well past the expected run length.
   initial begin
      #600000;
      n_fail++;
      finish_test();
   end
endmodule
